// ---- core/awd_adc_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module awd_adc_control
    import awd_pkg::*;
(
    // Clock and reset
    input  wire logic                 CLK_SYS,
    input  wire logic                 SYS_RST,
    // Special-function register port
    input  wire logic [7:0]           SFR_ADDR,
    input  wire logic                 SFR_WE,
    input  wire logic [7:0]           SFR_WDATA,
    output logic      [7:0]           SFR_RDATA,
    // Timer overflow events and modes
    input  wire logic                 TMR0_OVF,
    input  wire logic                 TMR1_OVF,
    input  wire logic                 TMR2_LO_OVF,
    input  wire logic                 TMR2_HI_OVF,
    input  wire logic                 TMR2_8BIT,
    input  wire logic                 TMR3_LO_OVF,
    input  wire logic                 TMR3_HI_OVF,
    input  wire logic                 TMR3_8BIT,
    // External start pin
    input  wire logic                 EXTERNAL_START_PIN,
    // Converter core
    output awd_ana_s                  ANA_CTRL,
    input  wire logic                 CONV_DONE,
    input  wire logic [AWD_RES_W-1:0] CONV_RESULT
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [4:0]       negative_input_code;
    logic [4:0]       sar_clock_divisor;
    logic             left_align_select;
    logic [7:0]       result_low_byte;
    logic [7:0]       result_high_byte;
    logic [7:0]       window_upper_limit_low;
    logic [7:0]       window_upper_limit_high;
    logic [7:0]       window_lower_limit_low;
    logic [7:0]       window_lower_limit_high;
    logic             converter_enable;
    logic             low_power_track_select;
    logic             conversion_done_flag;
    logic             window_match_flag;
    logic [2:0]       start_trigger_select;
    awd_state_e       state;
    logic [4:0]       div_cnt;
    logic [1:0]       track_cnt;
    logic             pin_q;
    logic             start_pulse;

    logic             wr_neg;
    logic             wr_cfg;
    logic             wr_ctrl;
    logic             clk_tick;
    logic             diff_mode;
    logic             pin_rise;
    logic             trig_hit;
    logic             conv_end;
    logic [15:0]      next_word;
    logic [15:0]      key_word;
    logic [15:0]      key_gt;
    logic [15:0]      key_lt;
    logic             win_match;

    // Register write decodes
    assign wr_neg  = SFR_WE && SFR_ADDR == AWD_ADDR_NEG;
    assign wr_cfg  = SFR_WE && SFR_ADDR == AWD_ADDR_CFG;
    assign wr_ctrl = SFR_WE && SFR_ADDR == AWD_ADDR_CTRL;

    ////////////////////////////////////////////////////////////////////////////
    // Negative select and configuration; unused bits are never stored
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            negative_input_code <= AWD_RST_NEG[4:0];
            sar_clock_divisor   <= AWD_RST_CFG[7:AWD_CFG_SC_LSB];
            left_align_select   <= AWD_RST_CFG[AWD_CFG_LJST];
        end else begin
            if (wr_neg) begin
                negative_input_code <= SFR_WDATA[4:0];
            end
            if (wr_cfg) begin
                sar_clock_divisor <= SFR_WDATA[7:AWD_CFG_SC_LSB];
                left_align_select <= SFR_WDATA[AWD_CFG_LJST];
            end
        end
    end

    // Ground as negative input is the only single-ended selection
    assign diff_mode = negative_input_code != AWD_NEG_GROUND;

    ////////////////////////////////////////////////////////////////////////////
    // Window limit bytes
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            window_upper_limit_low  <= AWD_RST_GT;
            window_upper_limit_high <= AWD_RST_GT;
            window_lower_limit_low  <= AWD_RST_LT;
            window_lower_limit_high <= AWD_RST_LT;
        end else if (SFR_WE) begin
            case (SFR_ADDR)
                AWD_ADDR_GT_LO: window_upper_limit_low  <= SFR_WDATA;
                AWD_ADDR_GT_HI: window_upper_limit_high <= SFR_WDATA;
                AWD_ADDR_LT_LO: window_lower_limit_low  <= SFR_WDATA;
                AWD_ADDR_LT_HI: window_lower_limit_high <= SFR_WDATA;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion clock divider; held at zero while shut down to save power
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || !converter_enable || clk_tick) begin
            div_cnt <= 5'h00;
        end else begin
            div_cnt <= div_cnt + 5'h01;
        end
    end

    assign clk_tick = converter_enable && div_cnt == sar_clock_divisor;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger selection; pin is synchronous so one flop gives the edge
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= EXTERNAL_START_PIN;
        end
    end

    assign pin_rise = EXTERNAL_START_PIN && !pin_q;

    always_comb begin
        case (start_trigger_select)
            AWD_TRIG_BUSY: trig_hit = wr_ctrl && SFR_WDATA[AWD_CTRL_BUSY];
            AWD_TRIG_TMR0: trig_hit = TMR0_OVF;
            AWD_TRIG_TMR2: trig_hit = TMR2_8BIT ? TMR2_LO_OVF : TMR2_HI_OVF;
            AWD_TRIG_TMR1: trig_hit = TMR1_OVF;
            AWD_TRIG_PIN:  trig_hit = pin_rise;
            AWD_TRIG_TMR3: trig_hit = TMR3_8BIT ? TMR3_LO_OVF : TMR3_HI_OVF;
            default:       trig_hit = 1'b0;                                   // Reserved codes never start
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer; the pin in low-power mode has already tracked, so it skips TRACK
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || !converter_enable) begin
            state     <= AWD_ST_IDLE;
            track_cnt <= 2'h0;
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= 1'b0;
            case (state)
                AWD_ST_IDLE: begin
                    track_cnt <= 2'h0;
                    if (trig_hit) begin
                        if (low_power_track_select && start_trigger_select != AWD_TRIG_PIN) begin
                            state <= AWD_ST_TRACK;
                        end else begin
                            state       <= AWD_ST_CONV;
                            start_pulse <= 1'b1;
                        end
                    end
                end
                AWD_ST_TRACK: begin
                    if (clk_tick) begin
                        track_cnt <= track_cnt + 2'h1;
                        if (track_cnt == AWD_TRACK_CLOCKS - 2'h1) begin
                            state       <= AWD_ST_CONV;
                            start_pulse <= 1'b1;
                        end
                    end
                end
                AWD_ST_CONV: begin
                    if (CONV_DONE) begin
                        state <= AWD_ST_IDLE;
                    end
                end
                default: state <= AWD_ST_IDLE;
            endcase
        end
    end

    assign conv_end = state == AWD_ST_CONV && CONV_DONE;

    ////////////////////////////////////////////////////////////////////////////
    // Result formatting and window compare on the word being loaded
    always_comb begin
        if (left_align_select) begin
            next_word = {CONV_RESULT, 6'h00};
        end else begin
            next_word = {{6{CONV_RESULT[AWD_RES_W-1]}}, CONV_RESULT};
        end
    end

    // Flipping the top bit turns a signed compare into an unsigned one
    assign key_word = {next_word[15] ^ diff_mode, next_word[14:0]};
    assign key_gt   = {window_upper_limit_high[7] ^ diff_mode, window_upper_limit_high[6:0],
                       window_upper_limit_low};
    assign key_lt   = {window_lower_limit_high[7] ^ diff_mode, window_lower_limit_high[6:0],
                       window_lower_limit_low};

    always_comb begin
        if (key_lt > key_gt) begin
            win_match = key_word > key_gt && key_word < key_lt;
        end else begin
            win_match = key_word < key_lt || key_word > key_gt;
        end
    end

    // Result bytes load on completion; software may also overwrite them
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            result_low_byte  <= AWD_RST_RES;
            result_high_byte <= AWD_RST_RES;
        end else if (conv_end) begin
            result_high_byte <= next_word[15:8];
            result_low_byte  <= next_word[7:0];
        end else if (SFR_WE && SFR_ADDR == AWD_ADDR_RES_LO) begin
            result_low_byte  <= SFR_WDATA;
        end else if (SFR_WE && SFR_ADDR == AWD_ADDR_RES_HI) begin
            result_high_byte <= SFR_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register; a hardware set wins over a software clear in one cycle
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            converter_enable       <= AWD_RST_CTRL[AWD_CTRL_EN];
            low_power_track_select <= AWD_RST_CTRL[AWD_CTRL_LP];
            conversion_done_flag   <= AWD_RST_CTRL[AWD_CTRL_DONE];
            window_match_flag      <= AWD_RST_CTRL[AWD_CTRL_WIN];
            start_trigger_select   <= AWD_RST_CTRL[2:0];
        end else begin
            if (wr_ctrl) begin
                converter_enable       <= SFR_WDATA[AWD_CTRL_EN];
                low_power_track_select <= SFR_WDATA[AWD_CTRL_LP];
                start_trigger_select   <= SFR_WDATA[2:0];
            end
            conversion_done_flag <= conv_end
                || (wr_ctrl ? SFR_WDATA[AWD_CTRL_DONE] : conversion_done_flag);
            window_match_flag    <= (conv_end && win_match)
                || (wr_ctrl ? SFR_WDATA[AWD_CTRL_WIN] : window_match_flag);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, one cycle behind the address
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            SFR_RDATA <= 8'h00;
        end else begin
            case (SFR_ADDR)
                AWD_ADDR_NEG:    SFR_RDATA <= {3'h0, negative_input_code};
                AWD_ADDR_CFG:    SFR_RDATA <= {sar_clock_divisor, left_align_select, 2'h0};
                AWD_ADDR_RES_LO: SFR_RDATA <= result_low_byte;
                AWD_ADDR_RES_HI: SFR_RDATA <= result_high_byte;
                AWD_ADDR_GT_LO:  SFR_RDATA <= window_upper_limit_low;
                AWD_ADDR_GT_HI:  SFR_RDATA <= window_upper_limit_high;
                AWD_ADDR_LT_LO:  SFR_RDATA <= window_lower_limit_low;
                AWD_ADDR_LT_HI:  SFR_RDATA <= window_lower_limit_high;
                AWD_ADDR_CTRL:   SFR_RDATA <= {converter_enable, low_power_track_select,
                                               conversion_done_flag, state != AWD_ST_IDLE,
                                               window_match_flag, start_trigger_select};
                default:         SFR_RDATA <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog controls; tracking stops whenever the sampler holds for a conversion
    always_comb begin
        ANA_CTRL.neg_code  = negative_input_code;
        ANA_CTRL.diff_mode = diff_mode;
        ANA_CTRL.power_on  = converter_enable;
        ANA_CTRL.start     = start_pulse;
        ANA_CTRL.clk_tick  = clk_tick;
        if (!converter_enable || state == AWD_ST_CONV) begin
            ANA_CTRL.track = 1'b0;
        end else if (!low_power_track_select) begin
            ANA_CTRL.track = 1'b1;
        end else if (start_trigger_select == AWD_TRIG_PIN) begin
            ANA_CTRL.track = !EXTERNAL_START_PIN;
        end else begin
            ANA_CTRL.track = state == AWD_ST_TRACK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    single_ended_a: assert property (ANA_CTRL.diff_mode == (negative_input_code != 5'h11))
        else $error("mode does not follow negative select");
    neg_unused_a: assert property (SFR_ADDR == AWD_ADDR_NEG |=> SFR_RDATA[7:5] == 3'h0)
        else $error("negative select unused bits not zero");
    divider_tick_a: assert property (clk_tick |=> !clk_tick || sar_clock_divisor == 5'h00)
        else $error("conversion clock tick too early");
    right_sign_a: assert property (conv_end && !left_align_select |=>
        result_high_byte[7:2] == {6{result_high_byte[1]}})
        else $error("right aligned high byte not sign extended");
    left_zero_a: assert property (conv_end && left_align_select |=> result_low_byte[5:0] == 6'h00)
        else $error("left aligned low bits not zero");
    shutdown_a: assert property (!converter_enable |-> !ANA_CTRL.track ##1 state == AWD_ST_IDLE)
        else $error("converter active while disabled");
    normal_track_a: assert property (converter_enable && !low_power_track_select
        && state != AWD_ST_CONV |-> ANA_CTRL.track)
        else $error("normal mode not tracking");
    done_flag_a: assert property (conv_end |=> conversion_done_flag && state == AWD_ST_IDLE)
        else $error("done flag not set at end of conversion");
    busy_start_a: assert property (state == AWD_ST_IDLE && converter_enable && wr_ctrl
        && SFR_WDATA[AWD_CTRL_EN] && SFR_WDATA[AWD_CTRL_BUSY] && !low_power_track_select
        && start_trigger_select == AWD_TRIG_BUSY |=> start_pulse ##1 state == AWD_ST_CONV)
        else $error("busy write did not start conversion");
    window_set_a: assert property (conv_end && win_match |=> window_match_flag [*2]
        or (window_match_flag ##1 $past(wr_ctrl)))
        else $error("window flag not held");
    lp_track_a: assert property (state == AWD_ST_TRACK && clk_tick && track_cnt == 2'h2
        && converter_enable |=> state == AWD_ST_CONV && start_pulse)
        else $error("tracking did not end after three clocks");

endmodule // awd_adc_control
`default_nettype wire

// ---- pkg/awd_pkg.sv ----
`default_nettype none
package awd_pkg;
    // Register addresses on the special-function bus
    localparam logic [7:0] AWD_ADDR_NEG    = 8'hBA;
    localparam logic [7:0] AWD_ADDR_CFG    = 8'hBC;
    localparam logic [7:0] AWD_ADDR_RES_LO = 8'hBD;
    localparam logic [7:0] AWD_ADDR_RES_HI = 8'hBE;
    localparam logic [7:0] AWD_ADDR_GT_LO  = 8'hC3;
    localparam logic [7:0] AWD_ADDR_GT_HI  = 8'hC4;
    localparam logic [7:0] AWD_ADDR_LT_LO  = 8'hC5;
    localparam logic [7:0] AWD_ADDR_LT_HI  = 8'hC6;
    localparam logic [7:0] AWD_ADDR_CTRL   = 8'hE8;

    // Values after reset
    localparam logic [7:0] AWD_RST_NEG    = 8'h1F;
    localparam logic [7:0] AWD_RST_CFG    = 8'hF8;
    localparam logic [7:0] AWD_RST_RES    = 8'h00;
    localparam logic [7:0] AWD_RST_GT     = 8'hFF;
    localparam logic [7:0] AWD_RST_LT     = 8'h00;
    localparam logic [7:0] AWD_RST_CTRL   = 8'h00;

    // Control register bit positions
    localparam int AWD_CTRL_EN   = 7;
    localparam int AWD_CTRL_LP   = 6;
    localparam int AWD_CTRL_DONE = 5;
    localparam int AWD_CTRL_BUSY = 4;
    localparam int AWD_CTRL_WIN  = 3;

    // Configuration register bit positions
    localparam int AWD_CFG_SC_LSB = 3;
    localparam int AWD_CFG_LJST   = 2;

    // Negative input code that selects ground, and the result width
    localparam logic [4:0] AWD_NEG_GROUND = 5'h11;
    localparam int         AWD_RES_W      = 10;

    // Conversion clocks of tracking before a low-power conversion
    localparam logic [1:0] AWD_TRACK_CLOCKS = 2'h3;

    // Start-of-conversion sources
    typedef enum logic [2:0] {
        AWD_TRIG_BUSY = 3'b000,
        AWD_TRIG_TMR0 = 3'b001,
        AWD_TRIG_TMR2 = 3'b010,
        AWD_TRIG_TMR1 = 3'b011,
        AWD_TRIG_PIN  = 3'b100,
        AWD_TRIG_TMR3 = 3'b101
    } awd_trig_e;

    // Sequencer states
    typedef enum logic [1:0] {
        AWD_ST_IDLE  = 2'b00,
        AWD_ST_TRACK = 2'b01,
        AWD_ST_CONV  = 2'b10
    } awd_state_e;

    // Controls toward the multiplexer and converter core
    typedef struct packed {
        logic [4:0] neg_code;
        logic       diff_mode;
        logic       power_on;
        logic       track;
        logic       start;
        logic       clk_tick;
    } awd_ana_s;
endpackage
`default_nettype wire

// ---- sim/awd_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module awd_core_model
    import awd_pkg::*;
#(parameter int CONV_TICKS = 10)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Controls from the block, and the value to return
    input  wire awd_ana_s   ana,
    input  wire logic [9:0] value,
    // Answer toward the block
    output logic            done,
    output logic [9:0]      result
);
    logic [3:0] tick_cnt;
    logic       running;

    // Converts for a fixed count of conversion clocks; the result bus wanders outside the done pulse
    always_ff @(posedge clk) begin
        done   <= 1'b0;
        result <= ~result;
        if (rst) begin
            running  <= 1'b0;
            tick_cnt <= 4'h0;
            result   <= 10'h155;
        end else if (!ana.power_on) begin
            running <= 1'b0;
        end else if (ana.start) begin
            running  <= 1'b1;
            tick_cnt <= 4'h0;
        end else if (running && ana.clk_tick) begin
            tick_cnt <= tick_cnt + 4'h1;
            if (tick_cnt == 4'(CONV_TICKS - 1)) begin
                running <= 1'b0;
                done    <= 1'b1;
                result  <= value;
            end
        end
    end
endmodule // awd_core_model
`default_nettype wire

// ---- sim/awd_adc_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module awd_adc_control_test;
    import awd_pkg::*;
    logic       clk_sys = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_we = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [6:0] ev = 7'h00;
    logic [9:0] value = 10'h000;
    logic       t8 = 1'b1;
    time        wr_end = 0;
    awd_ana_s   ana;
    logic       cdone;
    logic [9:0] cres;
    int         error_cnt = 0;
    int         n_checks = 0;
    int         cyc = 0;
    logic [7:0] d;
    bit         seen;

    // Free-running system clock
    always #2 clk_sys = ~clk_sys;

    awd_adc_control u_awd_adc_control (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SFR_ADDR(sfr_addr), .SFR_WE(sfr_we),
        .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .TMR0_OVF(ev[0]), .TMR1_OVF(ev[1]), .TMR2_LO_OVF(ev[2]),
        .TMR2_HI_OVF(ev[3]), .TMR2_8BIT(t8), .TMR3_LO_OVF(ev[4]), .TMR3_HI_OVF(ev[5]), .TMR3_8BIT(!t8),
        .EXTERNAL_START_PIN(ev[6]), .ANA_CTRL(ana), .CONV_DONE(cdone), .CONV_RESULT(cres));
    awd_core_model u_awd_core_model (.clk(clk_sys), .rst(sys_rst), .ana(ana), .value(value), .done(cdone),
        .result(cres));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus tasks enter and leave 1 ns after a rising edge; back-to-back writes let one edge pass
    // so the strobe never falls and rises again in the same time step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        if ($time == wr_end) @(posedge clk_sys) #1;
        sfr_addr = a;
        sfr_we = 1'b1;
        sfr_wdata = v;
        @(posedge clk_sys) #1;
        sfr_we = 1'b0;
        wr_end = $time;
    endtask
    task automatic rd(input logic [7:0] a);
        sfr_addr = a;
        @(posedge clk_sys) #1;
        d = sfr_rdata;
    endtask
    task automatic watch;
        seen = 0;
        repeat (6) begin
            if (ana.start === 1'b1) seen = 1;
            @(posedge clk_sys) #1;
        end
    endtask
    // Bounded poll; a hang shows up as a wrong control value afterwards
    task automatic wait_idle;
        rd(AWD_ADDR_CTRL);
        for (int n = 0; n < 100 && d[AWD_CTRL_BUSY] !== 1'b0; n++) rd(AWD_ADDR_CTRL);
        chk(d[AWD_CTRL_BUSY], 1'b0);
    endtask
    task automatic pulse(input logic [6:0] x);
        ev = x;
        @(posedge clk_sys) #1;
        ev = 7'h00;
        watch;
    endtask
    task automatic lim(input logic [15:0] gt, input logic [15:0] lt);
        wr(AWD_ADDR_GT_HI, gt[15:8]);
        wr(AWD_ADDR_GT_LO, gt[7:0]);
        wr(AWD_ADDR_LT_HI, lt[15:8]);
        wr(AWD_ADDR_LT_LO, lt[7:0]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, an unmapped read, reserved bits and the mode derived from the negative select
    task automatic t_regs;
        logic [63:0] adr = 64'hBABCBDBEC4C6E800;
        logic [63:0] exp = 64'h1FF80000FF000000;
        for (int i = 0; i < 8; i++) begin
            rd(adr[i*8+:8]);
            chk(d, exp[i*8+:8]);
        end
        wr(AWD_ADDR_NEG, 8'hF1);
        rd(AWD_ADDR_NEG);
        chk(d, 8'h11);
        chk(ana.diff_mode, 1'b0);
        wr(AWD_ADDR_NEG, 8'h10);
        chk({ana.neg_code, ana.diff_mode}, 6'h21);
        wr(AWD_ADDR_CFG, 8'h0F);
        rd(AWD_ADDR_CFG);
        chk(d, 8'h0C);
    endtask
    // Software-started conversion; checks busy, flags and the two result bytes
    task automatic conv(input logic [7:0] cfg, input logic [9:0] r, input logic [15:0] w, input logic [7:0] c);
        wr(AWD_ADDR_CFG, cfg);
        value = r;
        wr(AWD_ADDR_CTRL, 8'h90);
        rd(AWD_ADDR_CTRL);
        rd(AWD_ADDR_CTRL);
        chk(d[AWD_CTRL_BUSY], 1'b1);
        wait_idle;
        chk(d, c);
        rd(AWD_ADDR_RES_HI);
        w[15:8] = w[15:8] ^ d;
        rd(AWD_ADDR_RES_LO);
        chk({w[15:8], d}, {8'h00, w[7:0]});
    endtask
    // Trigger table: a wrong source must not start, the selected one must
    task automatic t_trig;
        logic [21:0] tab [7] = '{{8'h81, 7'h02, 7'h01}, {8'h82, 7'h08, 7'h04}, {8'h83, 7'h01, 7'h02},
            {8'h84, 7'h10, 7'h40}, {8'h85, 7'h10, 7'h20}, {8'h86, 7'h7F, 7'h00}, {8'h87, 7'h7F, 7'h00}};
        logic [7:0] sw [4] = '{8'h00, 8'h10, 8'h81, 8'h91};
        for (int i = 0; i < 4; i++) begin
            wr(AWD_ADDR_CTRL, sw[i]);
            watch;
            chk({seen, ana.power_on}, {1'b0, sw[i][7]});
        end
        for (int i = 0; i < 7; i++) begin
            wr(AWD_ADDR_CTRL, tab[i][21:14]);
            pulse(tab[i][13:7]);
            chk(seen, 1'b0);
            pulse(tab[i][6:0]);
            chk(seen, tab[i][6:0] != 7'h00);
            wait_idle;
        end
        // Timer 2 in 16-bit mode and timer 3 in 8-bit mode swap which overflow counts
        t8 = 1'b0;
        for (int i = 0; i < 2; i++) begin
            wr(AWD_ADDR_CTRL, i ? 8'h85 : 8'h82);
            pulse(i ? 7'h20 : 7'h04);
            chk(seen, 1'b0);
            pulse(i ? 7'h10 : 7'h08);
            chk(seen, 1'b1);
            wait_idle;
        end
    endtask
    // Tick rate for two divisors, then three ticks of tracking before a low-power start
    task automatic t_lowpower;
        int n;
        for (int k = 1; k < 4; k += 2) begin
            wr(AWD_ADDR_CFG, 8'(k * 8));
            n = 0;
            repeat (24) begin
                if (ana.clk_tick === 1'b1) n++;
                @(posedge clk_sys) #1;
            end
            chk(16'(n), 16'(24 / (k + 1)));
        end
        wr(AWD_ADDR_CFG, 8'h08);
        wr(AWD_ADDR_CTRL, 8'hC0);
        wr(AWD_ADDR_CTRL, 8'hD0);
        n = 0;
        for (int i = 0; i < 40 && ana.start !== 1'b1; i++) begin
            if (ana.clk_tick === 1'b1) n++;
            @(posedge clk_sys) #1;
        end
        chk(16'(n), 16'h0003);
        wait_idle;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        t_regs;
        wr(AWD_ADDR_NEG, 8'h11);
        wr(AWD_ADDR_CTRL, 8'h80);
        conv(8'h08, 10'h2A5, 16'hFEA5, 8'hA0);
        conv(8'h0C, 10'h2A5, 16'hA940, 8'hA0);
        lim(16'h0040, 16'h0080);
        conv(8'h08, 10'h050, 16'h0050, 8'hA8);
        conv(8'h08, 10'h090, 16'h0090, 8'hA0);
        lim(16'h0080, 16'h0040);
        conv(8'h08, 10'h090, 16'h0090, 8'hA8);
        conv(8'h08, 10'h060, 16'h0060, 8'hA0);
        wr(AWD_ADDR_NEG, 8'h00);
        lim(16'hFFFF, 16'h0040);
        conv(8'h08, 10'h3FF, 16'hFFFF, 8'hA0);
        conv(8'h08, 10'h000, 16'h0000, 8'hA8);
        t_trig;
        t_lowpower;
        end_of_test;
    end

    // Cuts a hang short well beyond the expected run length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test;
        end
    end
endmodule // awd_adc_control_test
`default_nettype wire
